// *** hw/lcgis_pkg.sv ***
/*
  Constants for the logic cell gate input selection block: register indexes,
  byte addresses, field positions and reset values.
  Assumes a 32-bit AXI4-Lite register bus with 16-bit byte addresses.
*/
package lcgis_pkg;

  // Bus widths
  localparam int unsigned LCGIS_ADDR_W = 16;
  localparam int unsigned LCGIS_DATA_W = 32;

  // Register indexes; the byte address is four times the index
  localparam logic [15:0] LCGIS_POL_IDX  = 16'h048A;
  localparam logic [15:0] LCGIS_SEL_IDX  = 16'h048C;
  localparam logic [15:0] LCGIS_LOW_IDX  = 16'h0490;
  localparam logic [15:0] LCGIS_HIGH_IDX = 16'h0492;
  localparam logic [15:0] LCGIS_STAT_IDX = 16'h0494;

  localparam logic [15:0] LCGIS_POL_ADDR  = {LCGIS_POL_IDX[13:0], 2'h0};
  localparam logic [15:0] LCGIS_SEL_ADDR  = {LCGIS_SEL_IDX[13:0], 2'h0};
  localparam logic [15:0] LCGIS_LOW_ADDR  = {LCGIS_LOW_IDX[13:0], 2'h0};
  localparam logic [15:0] LCGIS_HIGH_ADDR = {LCGIS_HIGH_IDX[13:0], 2'h0};
  localparam logic [15:0] LCGIS_STAT_ADDR = {LCGIS_STAT_IDX[13:0], 2'h0};

  // Reset values
  localparam logic [15:0] LCGIS_SEL_RST  = 16'h0000;
  localparam logic [15:0] LCGIS_GLS_RST  = 16'h0000;
  localparam logic [3:0]  LCGIS_POL_RST  = 4'h0;

  // Field layout
  localparam int unsigned LCGIS_NGATE    = 4;
  localparam int unsigned LCGIS_NSRC     = 4;
  localparam int unsigned LCGIS_SEL_W    = 3;
  localparam int unsigned LCGIS_SEL_STEP = 4;
  localparam int unsigned LCGIS_GATE_W   = 8;

  // Write mask of the selector register (bits 15, 11, 7, 3 unimplemented)
  localparam logic [15:0] LCGIS_SEL_MASK = 16'h7777;

  // AXI responses
  localparam logic [1:0] LCGIS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LCGIS_RESP_DECERR = 2'h3;

endpackage

// *** hw/lcgis_gate.sv ***
/*
  One gate of the logic cell input stage: OR of the enabled true and
  inverted data sources, followed by the output polarity stage.
  Assumes enables come from registers in the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module lcgis_gate #(
  parameter int unsigned NSRC = 4
) (
  // Data sources
  input  wire logic [NSRC-1:0] src,
  // Enables
  input  wire logic [NSRC-1:0] trueEn,
  input  wire logic [NSRC-1:0] invEn,
  input  wire logic            invertOut,
  // Result
  output wire logic            gateOut
);

  logic rawOr;

  // A cleared enable drops that form; nothing enabled gives 0
  assign rawOr = |((src & trueEn) | (~src & invEn));

  // Purely combinational so enable changes show at once
  assign gateOut = rawOr ^ invertOut;

endmodule

`default_nettype wire

// *** hw/lcgis_top.sv ***
/*
  Gate input selection matrix of one configurable logic cell, with its
  AXI4-Lite register slave, source selectors and gate polarity stage.
  Assumes source inputs are synchronous to mclk and a single-beat master.
*/
// How it works
// - Gate 2 takes source 2 and source 1 true when low-register bits 11 and 9 are set.
// - Gate 2 takes source 3, 2 and 1 inverted when low-register bits 12, 10 and 8 are set.
// - Gate 1 takes sources 4, 3, 2 and 1 true when low-register bits 7, 5, 3 and 1 are set.
// - Gate 1 takes sources 4, 3, 2 and 1 inverted when low-register bits 6, 4, 2 and 0 are set.
// - Gate 4 takes sources 4, 3, 2 and 1 true when high-register bits 15, 13, 11 and 9 are set.
// - Gate 4 takes sources 4, 3, 2 and 1 inverted when high-register bits 14, 12, 10 and 8 are set.
// - Gate 3 takes sources 4, 3 and 2 true when high-register bits 7, 5 and 3 are set.
// - Gate 3 takes sources 4 and 3 inverted when high-register bits 6 and 4 are set.
// - A cleared enable bit keeps that form of the source out of the gate.
// - The high select register sits at index 0x492, all sixteen bits read/write, reset 0.
// - The low select register sits at index 0x490, all sixteen bits read/write, reset 0.
// - A set polarity bit inverts its gate's output, a clear one passes it unchanged.
// - Each data source is one of eight inputs picked by a 3-bit selector.
// - Gate 3 takes source 1 true on high bit 1, source 1 inverted on bit 0, source 2 inverted on bit 2.
`timescale 1ns/1ns
`default_nettype none

module lcgis_top
  import lcgis_pkg::*;
#(
  parameter int unsigned NSRC_IN = 8
) (
  // Clock and reset
  input  wire logic                              mclk,
  input  wire logic                              rst_b,
  // Write address channel
  input  wire logic [lcgis_pkg::LCGIS_ADDR_W-1:0] awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  // Write data channel
  input  wire logic [lcgis_pkg::LCGIS_DATA_W-1:0] wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  // Write response channel
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  // Read address channel
  input  wire logic [lcgis_pkg::LCGIS_ADDR_W-1:0] araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  // Read data channel
  output logic [lcgis_pkg::LCGIS_DATA_W-1:0]      rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  // Candidate signals for each data source
  input  wire logic [NSRC_IN-1:0]                srcIn1,
  input  wire logic [NSRC_IN-1:0]                srcIn2,
  input  wire logic [NSRC_IN-1:0]                srcIn3,
  input  wire logic [NSRC_IN-1:0]                srcIn4,
  // Gate outputs after polarity
  output wire logic [lcgis_pkg::LCGIS_NGATE-1:0]  gateOut
);

  import lcgis_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] selLow_q;
  logic [15:0] selHigh_q;
  logic [15:0] srcSel_q;
  logic [3:0]  gatePol_q;

  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  logic        wrTake;
  logic        rdTake;
  logic [1:0]  wrLane;
  logic        wrHit;
  logic        rdHit;
  logic [31:0] rdData_d;

  //////////////////////////////////////////////////////////////////////////////
  // Write path: address and data are taken together, one at a time

  assign wrTake = awvalid && wvalid && !awready_q && !bvalid_q;
  assign wrLane = wstrb[1:0];

  always_comb begin
    unique case (awaddr)
      LCGIS_POL_ADDR, LCGIS_SEL_ADDR, LCGIS_LOW_ADDR,
      LCGIS_HIGH_ADDR, LCGIS_STAT_ADDR: wrHit = 1'b1;
      default:                          wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end else begin
      awready_q <= wrTake;
      wready_q  <= wrTake;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q  <= LCGIS_RESP_OKAY;
    end else if (awready_q) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wrHit ? LCGIS_RESP_OKAY : LCGIS_RESP_DECERR;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Low and high select registers, byte lanes honoured
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      selLow_q  <= LCGIS_GLS_RST;
      selHigh_q <= LCGIS_GLS_RST;
    end else if (awready_q) begin
      if (awaddr == LCGIS_LOW_ADDR) begin
        if (wrLane[0]) selLow_q[7:0] <= wdata[7:0];
        if (wrLane[1]) selLow_q[15:8] <= wdata[15:8];
      end
      if (awaddr == LCGIS_HIGH_ADDR) begin
        if (wrLane[0]) selHigh_q[7:0] <= wdata[7:0];
        if (wrLane[1]) selHigh_q[15:8] <= wdata[15:8];
      end
    end
  end

  // Source selector and polarity registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      srcSel_q  <= LCGIS_SEL_RST;
      gatePol_q <= LCGIS_POL_RST;
    end else if (awready_q) begin
      if (awaddr == LCGIS_SEL_ADDR) begin
        if (wrLane[0]) srcSel_q[7:0] <= wdata[7:0] & LCGIS_SEL_MASK[7:0];
        if (wrLane[1]) srcSel_q[15:8] <= wdata[15:8] & LCGIS_SEL_MASK[15:8];
      end
      if (awaddr == LCGIS_POL_ADDR && wrLane[0]) begin
        gatePol_q <= wdata[3:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path: one cycle to arready, data the cycle after

  assign rdTake = arvalid && !arready_q && !rvalid_q;

  always_comb begin
    rdHit    = 1'b1;
    rdData_d = 32'h00000000;
    unique case (araddr)
      LCGIS_POL_ADDR:  rdData_d = {28'h0000000, gatePol_q};
      LCGIS_SEL_ADDR:  rdData_d = {16'h0000, srcSel_q};
      LCGIS_LOW_ADDR:  rdData_d = {16'h0000, selLow_q};
      LCGIS_HIGH_ADDR: rdData_d = {16'h0000, selHigh_q};
      LCGIS_STAT_ADDR: rdData_d = {28'h0000000, gateOut};
      default:         rdHit    = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      arready_q <= 1'b0;
    end else begin
      arready_q <= rdTake;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rresp_q  <= LCGIS_RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end else if (arready_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rdHit ? LCGIS_RESP_OKAY : LCGIS_RESP_DECERR;
      rdata_q  <= rdData_d;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Data source selection and gates

  logic [LCGIS_NSRC-1:0]   dataSrc;
  logic [NSRC_IN-1:0]      srcAll [LCGIS_NSRC];
  logic [31:0]             enWord;

  assign srcAll[0] = srcIn1;
  assign srcAll[1] = srcIn2;
  assign srcAll[2] = srcIn3;
  assign srcAll[3] = srcIn4;
  // Gates 1 and 2 in the low register, gates 3 and 4 in the high one
  assign enWord = {selHigh_q, selLow_q};

  for (genvar s = 0; s < LCGIS_NSRC; s++) begin : g_src
    // Selector field s sits at bits 4s+2..4s
    assign dataSrc[s] = srcAll[s][srcSel_q[s*LCGIS_SEL_STEP +: LCGIS_SEL_W]];
  end

  for (genvar g = 0; g < LCGIS_NGATE; g++) begin : g_gate
    logic [LCGIS_NSRC-1:0] trueEn;
    logic [LCGIS_NSRC-1:0] invEn;
    for (genvar k = 0; k < LCGIS_NSRC; k++) begin : g_bit
      // Odd bit enables the true form, even bit the inverted one
      assign trueEn[k] = enWord[g*LCGIS_GATE_W + 2*k + 1];
      assign invEn[k]  = enWord[g*LCGIS_GATE_W + 2*k];
    end
    lcgis_gate #(
      .NSRC (LCGIS_NSRC)
    ) u_gate (
      .src       (dataSrc),
      .trueEn    (trueEn),
      .invEn     (invEn),
      .invertOut (gatePol_q[g]),
      .gateOut   (gateOut[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_reset_clear;
    $past(rst_b) == 1'b0 |-> selLow_q == 16'h0000 && selHigh_q == 16'h0000 && gateOut == 4'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("select registers not clear after reset");

  property p_low_write;
    awready_q && awaddr == LCGIS_LOW_ADDR && wstrb[1:0] == 2'h3
      |=> selLow_q == $past(wdata[15:0]) && bvalid;
  endproperty
  a_low_write: assert property (p_low_write) else $error("low register write lost");

  property p_high_read;
    arvalid && arready && araddr == LCGIS_HIGH_ADDR && !awready_q
      |=> rvalid && rdata == {16'h0000, $past(selHigh_q)};
  endproperty
  a_high_read: assert property (p_high_read) else $error("high register readback wrong");

  property p_g2_src1_true;
    selLow_q[15:8] == 8'h02 && !gatePol_q[1] |-> gateOut[1] == dataSrc[0];
  endproperty
  a_g2_src1_true: assert property (p_g2_src1_true) else $error("gate 2 source 1 true wrong");

  property p_g2_src3_inv;
    selLow_q[15:8] == 8'h10 && !gatePol_q[1] |-> gateOut[1] == !dataSrc[2];
  endproperty
  a_g2_src3_inv: assert property (p_g2_src3_inv) else $error("gate 2 source 3 inverted wrong");

  property p_g1_src4_true;
    selLow_q[7:0] == 8'h80 && !gatePol_q[0] |-> gateOut[0] == dataSrc[3];
  endproperty
  a_g1_src4_true: assert property (p_g1_src4_true) else $error("gate 1 source 4 true wrong");

  property p_g1_src2_inv;
    selLow_q[7:0] == 8'h04 && !gatePol_q[0] |-> gateOut[0] == !dataSrc[1];
  endproperty
  a_g1_src2_inv: assert property (p_g1_src2_inv) else $error("gate 1 source 2 inverted wrong");

  property p_g4_src3_true;
    selHigh_q[15:8] == 8'h20 && !gatePol_q[3] |-> gateOut[3] == dataSrc[2];
  endproperty
  a_g4_src3_true: assert property (p_g4_src3_true) else $error("gate 4 source 3 true wrong");

  property p_g4_src4_inv;
    selHigh_q[15:8] == 8'h40 && !gatePol_q[3] |-> gateOut[3] == !dataSrc[3];
  endproperty
  a_g4_src4_inv: assert property (p_g4_src4_inv) else $error("gate 4 source 4 inverted wrong");

  property p_g3_mix;
    selHigh_q[7:0] == 8'h18 && !gatePol_q[2] |-> gateOut[2] == (dataSrc[1] || !dataSrc[2]);
  endproperty
  a_g3_mix: assert property (p_g3_mix) else $error("gate 3 source 2 true or 3 inverted wrong");

  property p_g3_src1;
    selHigh_q[7:0] == 8'h03 && !gatePol_q[2] |-> gateOut[2] == 1'b1;
  endproperty
  a_g3_src1: assert property (p_g3_src1) else $error("gate 3 source 1 both forms not high");

  property p_none_enabled;
    enWord == 32'h00000000 |-> gateOut == gatePol_q;
  endproperty
  a_none_enabled: assert property (p_none_enabled) else $error("gate without inputs not at polarity level");

  property p_sel_pick;
    srcSel_q[2:0] == 3'h5 |-> dataSrc[0] == srcIn1[5];
  endproperty
  a_sel_pick: assert property (p_sel_pick) else $error("source 1 selector picks wrong input");

  property p_immediate;
    awready_q && awaddr == LCGIS_POL_ADDR && wstrb[0] && enWord == 32'h00000000
      |=> gateOut == $past(wdata[3:0]);
  endproperty
  a_immediate: assert property (p_immediate) else $error("polarity change not seen next cycle");

  c_write: cover property (awready_q && awaddr == LCGIS_LOW_ADDR ##1 bvalid && bready);
  c_read: cover property (arready_q && araddr == LCGIS_HIGH_ADDR ##1 rvalid && rready);
  c_gate_high: cover property (enWord != 32'h00000000 && gatePol_q == 4'h0 && gateOut == 4'hF);
  c_decerr: cover property (bvalid && bresp == LCGIS_RESP_DECERR);

endmodule

`default_nettype wire

// *** test/testbench.sv ***
/*
  Self-checking bench for the gate input selection block: AXI4-Lite master tasks,
  a reference gate model and a response monitor fed by expectation queues.
  Assumes lcgis_pkg and lcgis_top are compiled first; mclk runs at 100 MHz.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
  $display("BAD %0t mismatch got %h exp %h", $time, (got), (exp)); end end

module testbench;
  import lcgis_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic        mclk    = 1'b0;
  logic        rst_b   = 1'b0;
  logic [15:0] awaddr  = 16'h0000;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'h0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [15:0] araddr  = 16'h0000;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [7:0]  srcIn1  = 8'h00;
  logic [7:0]  srcIn2  = 8'h00;
  logic [7:0]  srcIn3  = 8'h00;
  logic [7:0]  srcIn4  = 8'h00;
  wire         awready;
  wire         wready;
  wire  [1:0]  bresp;
  wire         bvalid;
  wire         arready;
  wire  [31:0] rdata;
  wire  [1:0]  rresp;
  wire         rvalid;
  wire  [3:0]  gateOut;
  int          fails   = 0;
  int          checks  = 0;
  int          seed    = 32'h5BECADD5;
  logic [15:0] loV     = 16'h0000;
  logic [15:0] hiV     = 16'h0000;
  logic [15:0] selV    = 16'h0000;
  logic [3:0]  polV    = 4'h0;
  logic [1:0]  wrQ[$];
  logic [33:0] rdQ[$];

  lcgis_top u_lcgis_top (.mclk(mclk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .srcIn1(srcIn1), .srcIn2(srcIn2), .srcIn3(srcIn3), .srcIn4(srcIn4),
    .gateOut(gateOut));

  initial begin
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic [15:0] rnd();
    logic [31:0] t;
    t = $random(seed);
    return t[15:0];
  endfunction

  // Reference: OR of enabled true and inverted forms, then polarity
  function automatic logic [3:0] gmod();
    logic [3:0]  s;
    logic [31:0] en;
    logic [3:0]  r;
    s = {srcIn4[selV[14:12]], srcIn3[selV[10:8]], srcIn2[selV[6:4]], srcIn1[selV[2:0]]};
    en = {hiV, loV};
    r = 4'h0;
    for (int g = 0; g < 4; g++)
      for (int k = 0; k < 4; k++)
        r[g] = r[g] | (s[k] & en[8*g+2*k+1]) | (~s[k] & en[8*g+2*k]);
    return r ^ polV;
  endfunction

  // Each channel released at the edge that takes it; trailing edge avoids double drives
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er,
                        input logic [3:0] s = 4'hF);
    logic aw, w, b;
    int   n;
    wrQ.push_back(er);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    aw = 1'b1; w = 1'b1; b = 1'b1; n = 0;
    while ((aw || w || b) && n < 60) begin
      @(posedge mclk);
      n++;
      if (aw && awready === 1'b1) begin aw = 1'b0; awvalid <= 1'b0; end
      if (w && wready === 1'b1) begin w = 1'b0; wvalid <= 1'b0; end
      if (b && bvalid === 1'b1) begin b = 1'b0; bready <= 1'b0; end
    end
    if (aw || w || b) begin fails++; close_out(); end
    @(posedge mclk);
  endtask

  task automatic axi_rd(input logic [15:0] a, input logic [33:0] e);
    logic ar, r;
    int   n;
    rdQ.push_back(e);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    ar = 1'b1; r = 1'b1; n = 0;
    while ((ar || r) && n < 60) begin
      @(posedge mclk);
      n++;
      if (ar && arready === 1'b1) begin ar = 1'b0; arvalid <= 1'b0; end
      if (r && rvalid === 1'b1) begin r = 1'b0; rready <= 1'b0; end
    end
    if (ar || r) begin fails++; close_out(); end
    @(posedge mclk);
  endtask

  task automatic setall();
    axi_wr(LCGIS_LOW_ADDR, {16'h0000, loV}, LCGIS_RESP_OKAY);
    axi_wr(LCGIS_HIGH_ADDR, {16'h0000, hiV}, LCGIS_RESP_OKAY);
    axi_wr(LCGIS_SEL_ADDR, {16'h0000, selV}, LCGIS_RESP_OKAY);
    axi_wr(LCGIS_POL_ADDR, {28'h0000000, polV}, LCGIS_RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: pairs each bus answer with the oldest note
  always @(posedge mclk) begin
    if (rst_b === 1'b1 && bvalid === 1'b1 && bready === 1'b1) begin
      `CHK(bresp, (wrQ.size() > 0) ? wrQ.pop_front() : 2'hX)
    end
    if (rst_b === 1'b1 && rvalid === 1'b1 && rready === 1'b1) begin
      `CHK({rresp, rdata}, (rdQ.size() > 0) ? rdQ.pop_front() : 34'hX)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] en;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    {srcIn2, srcIn1} <= rnd();
    {srcIn4, srcIn3} <= rnd();
    #1; `CHK(gateOut, 4'h0)
    @(posedge mclk);
    // Reset values, unmapped place, ignored upper bits and masked selector
    axi_rd(LCGIS_LOW_ADDR, {LCGIS_RESP_OKAY, 32'h0000_0000});
    axi_rd(LCGIS_HIGH_ADDR, {LCGIS_RESP_OKAY, 32'h0000_0000});
    axi_rd(LCGIS_SEL_ADDR, {LCGIS_RESP_OKAY, 32'h0000_0000});
    axi_rd(LCGIS_POL_ADDR, {LCGIS_RESP_OKAY, 32'h0000_0000});
    axi_rd(16'h0000, {LCGIS_RESP_DECERR, 32'h0000_0000});
    axi_wr(16'h0000, 32'hFFFF_FFFF, LCGIS_RESP_DECERR);
    axi_wr(LCGIS_LOW_ADDR, 32'hABCD_5A3C, LCGIS_RESP_OKAY);
    axi_wr(LCGIS_HIGH_ADDR, 32'h1234_FFFF, LCGIS_RESP_OKAY);
    axi_wr(LCGIS_SEL_ADDR, 32'h0000_FFFF, LCGIS_RESP_OKAY);
    axi_rd(LCGIS_LOW_ADDR, {LCGIS_RESP_OKAY, 32'h0000_5A3C});
    axi_rd(LCGIS_HIGH_ADDR, {LCGIS_RESP_OKAY, 32'h0000_FFFF});
    axi_rd(LCGIS_SEL_ADDR, {LCGIS_RESP_OKAY, 32'h0000_7777});
    // Walk one enable bit at a time through both registers, both source levels
    selV = rnd() & LCGIS_SEL_MASK;
    axi_wr(LCGIS_SEL_ADDR, {16'h0000, selV}, LCGIS_RESP_OKAY);
    for (int i = 0; i < 32; i++) begin
      en = 32'h0000_0001 << i;
      loV = en[15:0];
      hiV = en[31:16];
      axi_wr(LCGIS_LOW_ADDR, {16'h0000, loV}, LCGIS_RESP_OKAY);
      axi_wr(LCGIS_HIGH_ADDR, {16'h0000, hiV}, LCGIS_RESP_OKAY);
      #1; `CHK(gateOut, gmod())
      for (int j = 0; j < 2; j++) begin
        @(posedge mclk);
        if (j == 0) begin
          {srcIn2, srcIn1} <= rnd();
          {srcIn4, srcIn3} <= rnd();
        end else begin
          {srcIn4, srcIn3, srcIn2, srcIn1} <= ~{srcIn4, srcIn3, srcIn2, srcIn1};
        end
        #1; `CHK(gateOut, gmod())
      end
      @(posedge mclk);
    end
    // Gate 3 two-input mixes, polarity with no inputs, single-lane write
    loV = 16'h0000;
    hiV = 16'h0018;
    setall();
    #1; `CHK(gateOut, gmod())
    @(posedge mclk);
    hiV = 16'h0003;
    axi_wr(LCGIS_HIGH_ADDR, {16'h0000, hiV}, LCGIS_RESP_OKAY);
    #1; `CHK(gateOut[2], 1'b1)
    @(posedge mclk);
    hiV = 16'h0000;
    polV = 4'hA;
    setall();
    #1; `CHK(gateOut, 4'hA)
    @(posedge mclk);
    axi_wr(LCGIS_LOW_ADDR, 32'h0000_A5C3, LCGIS_RESP_OKAY, 4'h2);
    axi_rd(LCGIS_LOW_ADDR, {LCGIS_RESP_OKAY, 32'h0000_A500});
    // Random enables, selectors and polarity; status word mirrors the gates
    for (int i = 0; i < 40; i++) begin
      loV = rnd();
      hiV = rnd();
      selV = rnd() & LCGIS_SEL_MASK;
      polV = 4'(rnd());
      {srcIn2, srcIn1} <= rnd();
      {srcIn4, srcIn3} <= rnd();
      setall();
      #1; `CHK(gateOut, gmod())
      @(posedge mclk);
      axi_rd(LCGIS_STAT_ADDR, {LCGIS_RESP_OKAY, 28'h0000000, gmod()});
    end
    repeat (4) @(posedge mclk);
    `CHK(wrQ.size() + rdQ.size(), 0)
    close_out();
  end
endmodule

`undef CHK
`default_nettype wire
